// ===== dv/spi_master.sv
// serial master model of the controlling processor
// assumes clk at 100 MHz; serial clock period 160 ns, still outside frames
`timescale 1ns/1ps
module spi_master (
  // clock
  input wire logic clk,
  // serial pins
  output adc_port_pkg::spi_pins_s spi,
  input wire logic miso_line
);
  import adc_port_pkg::*;
  logic idle = 1'b0;
  initial spi = '0;
  // clock level at select rise picks the edge variant
  task automatic begin_frame(input logic pol);
    idle = pol;
    spi.sck <= pol;
    repeat (4) @(posedge clk);
    spi.ce <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = '0;
    for (int i = 7; i > 7 - n; i--) begin
      spi.mosi <= tx[i];
      spi.sck <= ~idle;
      repeat (8) @(posedge clk);
      rx[i] = miso_line;
      spi.sck <= idle;
      repeat (8) @(posedge clk);
    end
  endtask
  task automatic end_frame();
    spi.ce <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ===== dv/tb.sv
// self-checking bench for the converter serial port and conversion control
// assumes the serial master model and a behavioural comparator
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module tb;
  import adc_port_pkg::*;
  logic clk = 0, rstn = 0, osc = 0, comparator_high = 0, flt = 0, low_seen;
  logic [3:0] oc = '0;
  logic miso_out, miso_oe_n, int_out, int_oe_n;
  logic [7:0] rd;
  spi_pins_s spi;
  analog_ctrl_s ana;
  realtime t_s0, t_s1, t_i;
  int mismatches = 0, compares = 0;
  // released data line shows a changing pattern; interrupt line is pulled up
  wire miso_line = miso_oe_n ? flt : miso_out;
  wire int_line = int_oe_n ? 1'b1 : int_out;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    flt <= ~flt;
    oc <= (oc == 4'h9) ? 4'h0 : oc + 4'h1;
    if (oc == 4'h9) osc <= ~osc;
    comparator_high <= ((ana.channel == 3'h5 ? 10'h2A5 : 10'h13C) >= ana.trial_code);
  end
  always @(posedge ana.sample) t_s0 = $realtime;
  always @(negedge ana.sample) t_s1 = $realtime;
  always @(negedge int_line) t_i = $realtime;
  spi_master m (.clk(clk), .spi(spi), .miso_line(miso_line));
  adc_port uut (.clk(clk), .rstn(rstn), .spi(spi), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
    .conversion_clock_pin(osc), .comparator_high(comparator_high), .ana(ana));
  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    m.begin_frame(1'b0);
    m.xfer({3'b100, a}, 8, rd);
    m.xfer(d, 8, rd);
    m.end_frame();
  endtask
  task automatic rd_burst(input logic pol, input logic [4:0] a, input logic [39:0] e,
    input int n);
    m.begin_frame(pol);
    `CHK(miso_oe_n, 1'b0)
    m.xfer({3'b000, a}, 8, rd);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'h00, 8, rd);
      `CHK(rd, e[39-8*i -: 8])
    end
    m.end_frame();
  endtask
  task automatic t_reset();
    `CHK(miso_oe_n, 1'b1)
    `CHK(int_line, 1'b1)
    rd_burst(1'b0, 5'h10, 40'h0, 1);
  endtask
  task automatic t_modes();
    m.begin_frame(1'b1);
    m.xfer(8'h90, 8, rd);
    m.xfer(8'h01, 8, rd);
    m.xfer(8'h06, 8, rd);
    m.end_frame();
    `CHK(ana.ref_ext, 1'b1)
    rd_burst(1'b0, 5'h10, 40'h01_06_00_00_00, 5);
  endtask
  task automatic t_partial();
    m.begin_frame(1'b0);
    m.xfer(8'h91, 8, rd);
    m.xfer(8'hFF, 4, rd);
    m.end_frame();
    `CHK(miso_oe_n, 1'b1)
    rd_burst(1'b1, 5'h11, {8'h06, 32'h0}, 1);
  endtask
  task automatic t_conv10();
    reg_wr(5'h10, 8'h0D);
    reg_wr(5'h12, 8'h05);
    `CHK(ana.channel, 3'h5)
    for (int i = 0; i < 400 && int_line !== 1'b0; i++) @(posedge clk);
    `CHK(int_line, 1'b0)
    `CHK((t_s1 - t_s0) > 250 && (t_s1 - t_s0) < 340, 1'b1)
    `CHK((t_i - t_s0) > 2650 && (t_i - t_s0) < 2900, 1'b1)
    rd_burst(1'b0, 5'h13, {8'h80, 32'h0}, 1);
    `CHK(int_line, 1'b1)
    rd_burst(1'b0, 5'h0A, {8'h02, 8'hA5, 24'h0}, 2);
  endtask
  task automatic t_conv8();
    reg_wr(5'h10, 8'h0A);
    `CHK(ana.ref_ext, 1'b0)
    reg_wr(5'h12, 8'h02);
    low_seen = 1'b0;
    repeat (400) @(posedge clk) low_seen |= ~int_line;
    `CHK(low_seen, 1'b0)
    rd_burst(1'b0, 5'h13, {8'h80, 32'h0}, 1);
    rd_burst(1'b1, 5'h05, {8'h4F, 32'h0}, 1);
  endtask
  task automatic final_report();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_modes();
    t_partial();
    t_conv10();
    t_conv8();
    final_report();
  end
endmodule

// ===== hw/adc_port.sv
// serial slave port, open-drain completion flag and conversion sequencing
// assumes pins and oscillator are asynchronous to clk; comparator from analog
`timescale 1ns/1ps
`include "adc_port_defs.svh"
// Behaviour
// - read bytes leave on the serial output most significant bit first.
// - serial output takes its next bit on each leading clock edge.
// - serial input is sampled on each trailing clock edge.
// - chip select low resets serial logic, output released.
// - first byte after chip select rises is the address/control byte.
// - later bytes under the same select are data reads or writes.
// - interrupt output signals a completed conversion.
// - interrupt is open drain: released when idle, driven low when active.
// - mode enable bit gates interrupt; status bit shows the condition.
// - conversion takes 14 or 12 oscillator cycles, sampling first 1.5.
// - conversion logic steps on the oscillator pin, not the serial clock.
// - reference select makes channel 0 the external reference.
// - one of eight channels, by channel address, feeds the converter.
// - clock level at select rise picks the active edges.
// - control byte: top bit direction, low five bits register address.
// - power-on reset clears the mode register.
module adc_port (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial pins
  input adc_port_pkg::spi_pins_s spi,
  output logic miso_out,
  output logic miso_oe_n,
  // completion interrupt, open drain
  output logic int_out,
  output logic int_oe_n,
  // conversion oscillator and analog front end
  input wire logic conversion_clock_pin,
  input wire logic comparator_high,
  output adc_port_pkg::analog_ctrl_s ana
);
  import adc_port_pkg::*;

  logic [1:0] ce_s, sck_s, mosi_s, osc_s, cmp_s;
  logic ce_q, sck_q, osc_q;
  logic pol, first_byte, dir_write;
  logic [2:0] bit_cnt;
  logic [7:0] rx, tx;
  logic [4:0] addr;
  logic [7:0] mode_selection_register, chsel, data_hi [8], data_lo [8];
  logic st_done;
  conv_state_e state;
  logic [4:0] half;
  logic [9:0] code;
  logic start_req;

  function automatic logic [4:0] addr_step(input logic [4:0] a);
    if (a <= `ADDR_DATA_LAST)
      addr_step = {1'b0, a[3:0] + 4'h1};
    else if (a < `ADDR_STATUS)
      addr_step = a + 5'h01;
    else
      addr_step = a;
  endfunction

  // edge finding on synchronised pins
  wire ce_on = ce_s[1];
  wire ce_rise = ce_s[1] & ~ce_q;
  wire active = ce_s[1] & ce_q;
  wire sck_rise = sck_s[1] & ~sck_q;
  wire sck_fall = ~sck_s[1] & sck_q;
  wire lead = active & (pol ? sck_fall : sck_rise);
  wire trail = active & (pol ? sck_rise : sck_fall);
  wire [7:0] rx_next = {rx[6:0], mosi_s[1]};
  wire byte_done = trail & (bit_cnt == 3'h7);
  wire [4:0] next_addr = first_byte ? rx_next[4:0] : addr_step(addr);
  wire do_write = byte_done & ~first_byte & dir_write;
  wire wr_start = do_write & (addr == `ADDR_START);
  wire busy = (state == CV_RUN);
  wire ien = mode_selection_register[`MODE_IEN_BIT];
  wire eight = mode_selection_register[`MODE_EIGHT_BIT];

  // read selection at the address the next byte will come from
  wire [7:0] status_rd = {st_done, busy, 6'h00};
  wire [7:0] ctl_rd = (next_addr == `ADDR_MODE) ? mode_selection_register :
                      (next_addr == `ADDR_CHSEL) ? chsel :
                      (next_addr == `ADDR_START) ? {5'h00, ana.channel} :
                      (next_addr == `ADDR_STATUS) ? status_rd : 8'h00;
  wire [7:0] rd_data = next_addr[4] ? ctl_rd :
                       next_addr[0] ? data_lo[next_addr[3:1]] : data_hi[next_addr[3:1]];
  wire load_tx = byte_done & (first_byte | ~dir_write);
  wire read_status = load_tx & (next_addr == `ADDR_STATUS)
                     & ~(first_byte & rx_next[`CTRL_DIR_BIT]);

  // conversion timing in oscillator half cycles
  wire osc_edge = osc_s[1] ^ osc_q;
  wire [4:0] total_half = {eight ? `CONV_CYC_EIGHT : `CONV_CYC_TEN} << 1;
  wire [4:0] trial_end = `TRIAL_START + (eight ? 5'h10 : 5'h14);
  wire [4:0] half_off = half - `TRIAL_START;
  wire [3:0] bitsel = `RESULT_MSB - half_off[4:1];
  wire in_trial = busy & (half >= `TRIAL_START) & (half < trial_end);
  wire conv_end = busy & osc_edge & (half == total_half - 5'h01);
  wire conv_go = start_req & mode_selection_register[`MODE_CONV_EN_BIT];

  // synchronisers: first stage read by the second and by AST_DATA_AFTER
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ce_s <= 2'h0;
      sck_s <= 2'h0;
      mosi_s <= 2'h0;
      osc_s <= 2'h0;
      cmp_s <= 2'h0;
      ce_q <= 1'b0;
      sck_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      ce_s <= {ce_s[0], spi.ce};
      sck_s <= {sck_s[0], spi.sck};
      mosi_s <= {mosi_s[0], spi.mosi};
      osc_s <= {osc_s[0], conversion_clock_pin};
      cmp_s <= {cmp_s[0], comparator_high};
      ce_q <= ce_s[1];
      sck_q <= sck_s[1];
      osc_q <= osc_s[1];
    end
  end

  // serial shifter, held in reset while select is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pol <= 1'b0;
      first_byte <= 1'b1;
      dir_write <= 1'b0;
      bit_cnt <= 3'h0;
      rx <= 8'h00;
      tx <= 8'h00;
      addr <= 5'h00;
    end else if (!ce_on) begin
      first_byte <= 1'b1;
      bit_cnt <= 3'h0;
      tx <= 8'h00;
    end else begin
      if (ce_rise) begin
        pol <= sck_s[1];
        first_byte <= 1'b1;
      end
      if (trail) begin
        rx <= rx_next;
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (lead)
        tx <= {tx[6:0], 1'b0};
      if (byte_done) begin
        first_byte <= 1'b0;
        addr <= next_addr;
        if (first_byte)
          dir_write <= rx_next[`CTRL_DIR_BIT];
      end
      if (load_tx)
        tx <= rd_data;
    end
  end

  // serial output and its enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= ~ce_on;
      if (!ce_on)
        miso_out <= 1'b0;
      else if (lead)
        miso_out <= tx[7];
    end
  end

  // registers written from the port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_selection_register <= `MODE_RESET;
      chsel <= 8'h00;
      start_req <= 1'b0;
    end else begin
      start_req <= wr_start;
      if (do_write & (addr == `ADDR_MODE))
        mode_selection_register <= rx_next;
      if (do_write & (addr == `ADDR_CHSEL))
        chsel <= rx_next;
    end
  end

  // successive approximation sequencing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= CV_IDLE;
      half <= 5'h00;
      code <= 10'h000;
      st_done <= 1'b0;
      ana <= '0;
      for (int i = 0; i < 8; i++) begin
        data_hi[i] <= 8'h00;
        data_lo[i] <= 8'h00;
      end
    end else begin
      ana.ref_ext <= mode_selection_register[`MODE_REF_BIT];
      ana.trial_code <= code;
      if (read_status | conv_go)
        st_done <= 1'b0;
      case (state)
        CV_IDLE: begin
          if (conv_go) begin
            ana.channel <= rx[2:0];
            ana.sample <= 1'b1;
            // count starts at the first oscillator edge, so sampling spans full halves
            half <= `CONV_ARM;
            code <= 10'h000;
            state <= CV_RUN;
          end
        end
        CV_RUN: begin
          if (osc_edge) begin
            half <= half + 5'h01;
            if (half == `SAMPLE_HALVES - 5'h01)
              ana.sample <= 1'b0;
            if (in_trial & ~half[0])
              code[bitsel] <= 1'b1;
            if (in_trial & half[0] & ~cmp_s[1])
              code[bitsel] <= 1'b0;
          end
          if (conv_end) begin
            state <= CV_IDLE;
            st_done <= 1'b1;
            if (eight) begin
              data_lo[ana.channel] <= code[9:2];
            end else begin
              data_hi[ana.channel] <= {6'h00, code[9:8]};
              data_lo[ana.channel] <= code[7:0];
            end
          end
        end
        default: state <= CV_IDLE;
      endcase
    end
  end

  // open-drain interrupt: drive low only when flagged and enabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_out <= 1'b0;
      int_oe_n <= 1'b1;
    end else begin
      int_out <= 1'b0;
      int_oe_n <= ~(st_done & ien);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_ce_up;
    ce_rise ##1 first_byte;
  endsequence
  sequence s_lead_shift;
    lead & ~load_tx ##1 miso_out == $past(tx[7]);
  endsequence

  AST_FIRST_ADDR: assert property (ce_rise |-> s_ce_up)
    else $error("first byte not taken as address");
  AST_POL: assert property (ce_rise |=> pol == $past(sck_s[1]))
    else $error("edge polarity not latched");
  AST_MSB_OUT: assert property (lead & ~load_tx |-> s_lead_shift)
    else $error("output bit not top of shifter");
  AST_OUT_HOLD: assert property (active & ~lead ##1 active |-> $stable(miso_out))
    else $error("output changed off leading edge");
  AST_IN_SAMPLE: assert property (trail |=> rx[0] == $past(mosi_s[1]))
    else $error("input not sampled on trailing edge");
  AST_MISO_HIZ: assert property (!ce_on ##1 !ce_on |-> miso_oe_n && bit_cnt == 3'h0)
    else $error("serial output not released");
  AST_DATA_AFTER: assert property (byte_done & first_byte & ce_s[0] |=> !first_byte)
    else $error("address taken twice");
  AST_INT_DRAIN: assert property (int_out == 1'b0)
    else $error("interrupt driven high");
  AST_INT_GATE: assert property (##1 int_oe_n == !$past(st_done & ien))
    else $error("interrupt not gated by enable");
  AST_DONE: assert property (conv_end |=> st_done && state == CV_IDLE)
    else $error("completion not flagged");
  AST_SAMPLE: assert property (busy & (half >= `SAMPLE_HALVES) & (half != `CONV_ARM) |-> !ana.sample)
    else $error("sampling past one and a half cycles");
  AST_REF: assert property (##1 ana.ref_ext == $past(mode_selection_register[0]))
    else $error("reference select not followed");
  AST_MODE_RST: assert property ($rose(rstn) |-> mode_selection_register == 8'h00)
    else $error("mode register not cleared");
  AST_INT_RST: assert property ($rose(rstn) |-> int_oe_n)
    else $error("interrupt not released after reset");
  AST_HALF_STEP: assert property (busy & ~osc_edge |=> $stable(half))
    else $error("conversion stepped off oscillator edge");
  AST_CHAN_HOLD: assert property (busy |=> $stable(ana.channel))
    else $error("channel changed during conversion");
  AST_ADDR_HOLD: assert property (!byte_done |=> $stable(addr))
    else $error("address moved inside a byte");
  AST_TX_LOAD: assert property (load_tx |=> tx == $past(rd_data))
    else $error("read byte not loaded whole");
  AST_STATUS_CLR: assert property (read_status & ~conv_end |=> !st_done)
    else $error("status read did not clear done");
endmodule

// ===== hw/adc_port_defs.svh
// offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package and the design
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH
`define ADDR_CTL_BASE 5'h10
`define ADDR_MODE 5'h10
`define ADDR_CHSEL 5'h11
`define ADDR_START 5'h12
`define ADDR_STATUS 5'h13
`define ADDR_DATA_LAST 5'h0F
`define CTRL_DIR_BIT 7
`define MODE_REF_BIT 0
`define MODE_EIGHT_BIT 1
`define MODE_IEN_BIT 2
`define MODE_CONV_EN_BIT 3
`define MODE_RESET 8'h00
`define STATUS_DONE_BIT 7
`define STATUS_BUSY_BIT 6
`define CONV_CYC_TEN 5'h0E
`define CONV_CYC_EIGHT 5'h0C
`define SAMPLE_HALVES 5'h03
`define CONV_ARM 5'h1F
`define TRIAL_START 5'h04
`define RESULT_MSB 4'h9
`endif

// ===== hw/adc_port_pkg.sv
// types shared by the converter port and conversion control
// assumes adc_port_defs.svh on the include path
package adc_port_pkg;
  `include "adc_port_defs.svh"
  typedef struct packed {
    logic ce;
    logic sck;
    logic mosi;
  } spi_pins_s;
  typedef struct packed {
    logic [2:0] channel;
    logic ref_ext;
    logic sample;
    logic [9:0] trial_code;
  } analog_ctrl_s;
  typedef enum logic {CV_IDLE, CV_RUN} conv_state_e;
endpackage
